// ---- link_activity_cfg.svh ----
// register offsets, field positions and reset values of the activity monitor
`ifndef LINK_ACTIVITY_CFG_SVH
`define LINK_ACTIVITY_CFG_SVH

`define ACT_ADDR_W 8
`define ACT_FP_OFFSET 8'h0c
`define ACT_LINK_OFFSET 8'h10
`define ACT_LINK_TX_LSB 8
`define ACT_LINK_RX_LSB 0
`define ACT_FP_TX_HWY_LSB 8
`define ACT_FP_RX_HWY_LSB 4
`define ACT_FP_TX_FAST_BIT 3
`define ACT_RESET_VALUE 32'h0000_0000
`define ACT_LANES_OFF 4'hf
`define ACT_LINKS 32
`define ACT_GROUPS 8
`define ACT_HWYS 4

`endif

// ---- link_activity_pkg.sv ----
// types shared by the activity monitor files
package link_activity_pkg;

  typedef logic [31:0] word_type;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_FP = 2'b01,
    SEL_LINK = 2'b10
  } reg_sel_type;

endpackage

// ---- activity_event_sync.sv ----
// one activity detector: low-then-high sampling in the watched clock, handshake to ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module activity_event_sync #(
  parameter bit WATCH_CLOCK = 1'b0,
  parameter bit FALLING = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic watch_clk_i,
  input wire logic sample_i,
  output logic event_o
);

  // ----------------------------------------------------------------
  // watched clock domain
  // ----------------------------------------------------------------
  wire sample_clk = FALLING ? ~watch_clk_i : watch_clk_i;
  logic rst_meta_q;
  logic rst_link_q;
  logic prev_q;
  logic pend_q;
  logic req_q;
  logic ack_meta_q;
  logic ack_link_q;
  logic req_meta_q;
  logic req_ref_q;
  logic ack_q;

  // previous sample resets high so a pin that starts high is not counted
  wire rise = WATCH_CLOCK ? 1'b1 : (~prev_q & sample_i);
  wire want = pend_q | rise;
  wire fire = want & (req_q == ack_link_q);

  always_ff @(posedge sample_clk) begin
    rst_meta_q <= rst_i;
    rst_link_q <= rst_meta_q;
  end

  // events coalesce while a handshake is open, none is dropped
  always_ff @(posedge sample_clk) begin
    if (rst_link_q) begin
      prev_q <= 1'b1;
      pend_q <= 1'b0;
      req_q <= 1'b0;
      ack_meta_q <= 1'b0;
      ack_link_q <= 1'b0;
    end else begin
      prev_q <= sample_i;
      pend_q <= want & ~fire;
      req_q <= req_q ^ fire;
      ack_meta_q <= ack_q;
      ack_link_q <= ack_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // ref_clk_i domain
  // ----------------------------------------------------------------

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      req_meta_q <= 1'b0;
      req_ref_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      req_meta_q <= req_q;
      req_ref_q <= req_meta_q;
      ack_q <= req_ref_q;
    end
  end

  assign event_o = req_ref_q ^ ack_q;

endmodule // activity_event_sync

`default_nettype wire

// ---- link_clock_activity_monitor.sv ----
// link and frame pulse activity monitor with clear-on-read holding registers
//
// Contract
// - fast transmit frame pulse bit sets after low then high on its falling clock edges
// - receive highway frame pulse bit n sets after low then high on falling clock n
// - transmit highway frame pulse bit n sets after low then high on falling clock n
// - link register: transmit groups in bits 15:8, receive groups 7:0, rest zero
// - activity bits are sticky and read low only without activity since last read
// - a read returns current bits, then clears all bits of that register
// - any byte enable means full word; all enables negated means no access
// - receive group k sets when all four links saw low then high on line clocks
// - receive group k also sets from all four sampled on highway clock k/2
// - receive group k also sets from link 4k sampled on fast highway data clock
// - any one receive condition alone sets the group bit
// - transmit group 0..3 sets when all four line clocks of the group rose
// - transmit group 0..3 also sets on one rising edge of highway clock k
// - transmit group 4 sets only when line clocks of links 16 to 19 rose
// - transmit group 7 sets from its four line clocks or fast highway data clock
// - transmit groups 5 and 6 set only from their own four line clocks
`timescale 1ns/1ps
`default_nettype none

`include "link_activity_cfg.svh"

module link_clock_activity_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [`ACT_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] byte_lane_enables_n_i,
  output link_activity_pkg::word_type reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [`ACT_LINKS-1:0] rx_data_i,
  input wire logic [`ACT_LINKS-1:0] rx_line_clock_i,
  input wire logic [`ACT_HWYS-1:0] rx_hwy_clock_i,
  input wire logic rx_fast_hwy_data_clock_i,
  input wire logic [`ACT_HWYS-1:0] rx_hwy_frame_pulse_n_i,
  input wire logic [`ACT_LINKS-1:0] tx_line_clock_i,
  input wire logic [`ACT_HWYS-1:0] tx_hwy_clock_i,
  input wire logic tx_fast_hwy_data_clock_i,
  input wire logic [`ACT_HWYS-1:0] tx_hwy_frame_pulse_n_i,
  input wire logic tx_fast_hwy_fp_clock_i,
  input wire logic tx_fast_hwy_frame_pulse_n_i
);

  import link_activity_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // group k covers links 4k to 4k+3; all four must have shown activity
  function automatic logic all_four(input logic [`ACT_LINKS-1:0] seen, input int k);
    logic [3:0] part;
    part = seen[k*4 +: 4];
    return &part;
  endfunction

  // ----------------------------------------------------------------
  // detector events, all already in the ref_clk_i domain
  // ----------------------------------------------------------------
  logic [`ACT_LINKS-1:0] rx_line_ev;
  logic [`ACT_LINKS-1:0] rx_hwy_ev;
  logic [`ACT_GROUPS-1:0] rx_fast_ev;
  logic [`ACT_LINKS-1:0] tx_line_ev;
  logic [`ACT_HWYS-1:0] tx_hwy_ev;
  logic tx_fast_ev;
  logic [`ACT_HWYS-1:0] rx_fp_ev;
  logic [`ACT_HWYS-1:0] tx_fp_ev;
  logic tx_fast_fp_ev;
  // a watched clock that stops keeps a merged second event until it runs again

  genvar n;
  generate
    for (n = 0; n < `ACT_LINKS; n++) begin : g_link
      // receive data sampled on its own line clock
      activity_event_sync #(.WATCH_CLOCK(1'b0), .FALLING(1'b0)) u_rx_line (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(rx_line_clock_i[n]),
        .sample_i(rx_data_i[n]),
        .event_o(rx_line_ev[n])
      );
      // receive data sampled on the highway clock of its pair of groups
      activity_event_sync #(.WATCH_CLOCK(1'b0), .FALLING(1'b0)) u_rx_hwy (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(rx_hwy_clock_i[n/8]),
        .sample_i(rx_data_i[n]),
        .event_o(rx_hwy_ev[n])
      );
      // any rising edge of a transmit line clock counts
      activity_event_sync #(.WATCH_CLOCK(1'b1), .FALLING(1'b0)) u_tx_line (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(tx_line_clock_i[n]),
        .sample_i(1'b1),
        .event_o(tx_line_ev[n])
      );
    end

    for (n = 0; n < `ACT_GROUPS; n++) begin : g_fast
      // only the lowest link of each group is watched on the fast clock
      activity_event_sync #(.WATCH_CLOCK(1'b0), .FALLING(1'b0)) u_rx_fast (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(rx_fast_hwy_data_clock_i),
        .sample_i(rx_data_i[n*4]),
        .event_o(rx_fast_ev[n])
      );
    end

    for (n = 0; n < `ACT_HWYS; n++) begin : g_hwy
      // any rising edge of a transmit highway clock counts
      activity_event_sync #(.WATCH_CLOCK(1'b1), .FALLING(1'b0)) u_tx_hwy (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(tx_hwy_clock_i[n]),
        .sample_i(1'b1),
        .event_o(tx_hwy_ev[n])
      );
      // frame pulses are sampled on falling edges of their highway clock
      activity_event_sync #(.WATCH_CLOCK(1'b0), .FALLING(1'b1)) u_rx_fp (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(rx_hwy_clock_i[n]),
        .sample_i(rx_hwy_frame_pulse_n_i[n]),
        .event_o(rx_fp_ev[n])
      );
      activity_event_sync #(.WATCH_CLOCK(1'b0), .FALLING(1'b1)) u_tx_fp (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .watch_clk_i(tx_hwy_clock_i[n]),
        .sample_i(tx_hwy_frame_pulse_n_i[n]),
        .event_o(tx_fp_ev[n])
      );
    end
  endgenerate

  // any rising edge of the fast transmit data clock counts
  activity_event_sync #(.WATCH_CLOCK(1'b1), .FALLING(1'b0)) u_tx_fast (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .watch_clk_i(tx_fast_hwy_data_clock_i),
    .sample_i(1'b1),
    .event_o(tx_fast_ev)
  );

  activity_event_sync #(.WATCH_CLOCK(1'b0), .FALLING(1'b1)) u_tx_fast_fp (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .watch_clk_i(tx_fast_hwy_fp_clock_i),
    .sample_i(tx_fast_hwy_frame_pulse_n_i),
    .event_o(tx_fast_fp_ev)
  );

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  // lanes are not decoded: one enabled lane reads the whole word
  wire any_lane = (byte_lane_enables_n_i != `ACT_LANES_OFF);
  wire access = reg_rd_i & any_lane;
  wire addr_link = (reg_addr_i == `ACT_LINK_OFFSET);
  wire addr_fp = (reg_addr_i == `ACT_FP_OFFSET);
  // a refused or unmapped read still gets an answer, with zero data
  wire reg_sel_type sel = !access ? SEL_NONE :
                          addr_link ? SEL_LINK :
                          addr_fp ? SEL_FP : SEL_NONE;
  wire clr_link = (sel == SEL_LINK);
  wire clr_fp = (sel == SEL_FP);

  // ----------------------------------------------------------------
  // per-link seen bits, cleared with the link register
  // ----------------------------------------------------------------
  logic [`ACT_LINKS-1:0] rx_line_seen_q;
  logic [`ACT_LINKS-1:0] rx_hwy_seen_q;
  logic [`ACT_LINKS-1:0] tx_line_seen_q;

  // an event in the clearing cycle is kept: set wins over clear
  wire [`ACT_LINKS-1:0] rx_line_eff = (clr_link ? '0 : rx_line_seen_q) | rx_line_ev;
  wire [`ACT_LINKS-1:0] rx_hwy_eff = (clr_link ? '0 : rx_hwy_seen_q) | rx_hwy_ev;
  wire [`ACT_LINKS-1:0] tx_line_eff = (clr_link ? '0 : tx_line_seen_q) | tx_line_ev;

  // per-link memory lets the four links of a group show activity at different times
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_line_seen_q <= '0;
    end else begin
      rx_line_seen_q <= rx_line_eff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_hwy_seen_q <= '0;
    end else begin
      rx_hwy_seen_q <= rx_hwy_eff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_line_seen_q <= '0;
    end else begin
      tx_line_seen_q <= tx_line_eff;
    end
  end

  // ----------------------------------------------------------------
  // receive group conditions
  // ----------------------------------------------------------------
  logic [`ACT_GROUPS-1:0] rx_cond;
  logic [`ACT_GROUPS-1:0] tx_cond;

  generate
    for (n = 0; n < `ACT_GROUPS; n++) begin : g_rx_group
      wire by_line = all_four(rx_line_eff, n);
      wire by_hwy = all_four(rx_hwy_eff, n);
      wire by_fast = rx_fast_ev[n];
      // three independent ways in, any one suffices
      assign rx_cond[n] = by_line | by_hwy | by_fast;
    end
  endgenerate

  // ----------------------------------------------------------------
  // transmit group conditions
  // ----------------------------------------------------------------
  generate
    for (n = 0; n < `ACT_GROUPS; n++) begin : g_group
      wire by_line = all_four(tx_line_eff, n);
      if (n < `ACT_HWYS) begin : g_tx_hwy
        assign tx_cond[n] = by_line | tx_hwy_ev[n];
      end else if (n == `ACT_GROUPS - 1) begin : g_tx_fast
        assign tx_cond[n] = by_line | tx_fast_ev;
      end else begin : g_tx_line
        // groups 4 to 6 have no highway alternative
        assign tx_cond[n] = by_line;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // holding registers
  // ----------------------------------------------------------------
  logic [`ACT_GROUPS-1:0] rx_group_active_q;
  logic [`ACT_GROUPS-1:0] tx_group_active_q;
  logic [`ACT_HWYS-1:0] rx_hwy_fp_seen_q;
  logic [`ACT_HWYS-1:0] tx_hwy_fp_seen_q;
  logic tx_fast_hwy_fp_seen_q;

  // sticky until read; a read clears every bit of its own register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_group_active_q <= '0;
    end else begin
      rx_group_active_q <= (clr_link ? '0 : rx_group_active_q) | rx_cond;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_group_active_q <= '0;
    end else begin
      tx_group_active_q <= (clr_link ? '0 : tx_group_active_q) | tx_cond;
    end
  end

  // frame pulse bits clear only on a read of their own address
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rx_hwy_fp_seen_q <= '0;
    end else begin
      rx_hwy_fp_seen_q <= (clr_fp ? '0 : rx_hwy_fp_seen_q) | rx_fp_ev;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_hwy_fp_seen_q <= '0;
    end else begin
      tx_hwy_fp_seen_q <= (clr_fp ? '0 : tx_hwy_fp_seen_q) | tx_fp_ev;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_fast_hwy_fp_seen_q <= 1'b0;
    end else begin
      tx_fast_hwy_fp_seen_q <= (clr_fp ? 1'b0 : tx_fast_hwy_fp_seen_q) | tx_fast_fp_ev;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  word_type link_word;
  word_type fp_word;

  // unused upper bits read as zero
  always_comb begin
    link_word = `ACT_RESET_VALUE;
    link_word[`ACT_LINK_TX_LSB +: `ACT_GROUPS] = tx_group_active_q;
    link_word[`ACT_LINK_RX_LSB +: `ACT_GROUPS] = rx_group_active_q;
  end

  // system clock, receive fast pulse and test data bits are not monitored here
  always_comb begin
    fp_word = `ACT_RESET_VALUE;
    fp_word[`ACT_FP_TX_HWY_LSB +: `ACT_HWYS] = tx_hwy_fp_seen_q;
    fp_word[`ACT_FP_RX_HWY_LSB +: `ACT_HWYS] = rx_hwy_fp_seen_q;
    fp_word[`ACT_FP_TX_FAST_BIT] = tx_fast_hwy_fp_seen_q;
  end

  wire word_type rdata_d = clr_link ? link_word : clr_fp ? fp_word : `ACT_RESET_VALUE;

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // the word returned is the value before the clear takes effect
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `ACT_RESET_VALUE;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

  // every strobe is answered, refused ones included
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

endmodule // link_clock_activity_monitor

`default_nettype wire

// ---- link_clock_activity_monitor_checker.sv ----
// register port assertions for the activity monitor
`timescale 1ns/1ps
`default_nettype none
`include "link_activity_cfg.svh"
module link_clock_activity_monitor_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [`ACT_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] byte_lane_enables_n_i,
  input wire link_activity_pkg::word_type reg_rdata_o,
  input wire logic reg_rvalid_o
);
  import link_activity_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire logic lanes_on = byte_lane_enables_n_i != `ACT_LANES_OFF;
  wire logic mapped = reg_addr_i == `ACT_LINK_OFFSET || reg_addr_i == `ACT_FP_OFFSET;
  sequence s_taken(a);
    reg_rd_i && lanes_on && reg_addr_i == a;
  endsequence
  property p_answer; reg_rd_i |=> reg_rvalid_o; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_quiet; !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_idle; !reg_rvalid_o |-> reg_rdata_o == '0; endproperty
  a_idle: assert property (p_idle) else $error("data without valid");
  property p_link_unused; s_taken(`ACT_LINK_OFFSET) |=> reg_rdata_o[31:16] == 16'h0; endproperty
  a_link_unused: assert property (p_link_unused) else $error("link bits 31:16 set");
  property p_fp_unused;
    s_taken(`ACT_FP_OFFSET) |=> reg_rdata_o[31:12] == 20'h0 && reg_rdata_o[2:0] == 3'h0;
  endproperty
  a_fp_unused: assert property (p_fp_unused) else $error("unused pulse bits set");
  property p_no_lanes; reg_rd_i && !lanes_on |=> reg_rvalid_o && reg_rdata_o == '0; endproperty
  a_no_lanes: assert property (p_no_lanes) else $error("refused read gave data");
  property p_unmapped; reg_rd_i && !mapped |=> reg_rdata_o == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read gave data");
  property p_reset;
    disable iff (1'b0) rst_i |=> !reg_rvalid_o && reg_rdata_o == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("port busy in reset");
endmodule // link_clock_activity_monitor_checker
bind link_clock_activity_monitor link_clock_activity_monitor_checker i_checker (.ref_clk_i,
  .rst_i, .reg_addr_i, .reg_rd_i, .byte_lane_enables_n_i, .reg_rdata_o, .reg_rvalid_o);
`default_nettype wire

// ---- link_activity_model.sv ----
// line framer model: bursts of link clocks, data and frame pulses
`timescale 1ns/1ps
`default_nettype none
module link_activity_model (
  output var logic [31:0] rx_data_o,
  output var logic [31:0] rx_line_clock_o,
  output var logic [3:0] rx_hwy_clock_o,
  output var logic rx_fast_o,
  output var logic [3:0] rx_fp_n_o,
  output var logic [31:0] tx_line_clock_o,
  output var logic [3:0] tx_hwy_clock_o,
  output var logic tx_fast_o,
  output var logic [3:0] tx_fp_n_o,
  output var logic tx_fp_clock_o,
  output var logic tx_fast_fp_n_o
);
  initial begin
    {rx_line_clock_o, tx_line_clock_o, rx_hwy_clock_o, tx_hwy_clock_o} = '0;
    {rx_fast_o, tx_fast_o, tx_fp_clock_o} = '0;
    {rx_data_o, rx_fp_n_o, tx_fp_n_o, tx_fast_fp_n_o} = '1;
  end
  // --------------------------------------------------------------
  // burst of six 15 ns periods; clocks stand still outside it
  // --------------------------------------------------------------
  // two lead-in periods absorb the reset synchroniser of each watched clock
  task automatic burst(input logic [31:0] rl, tl, dm, input logic [3:0] rh, th, rp, tp,
                       input logic [2:0] f);
    for (int i = 0; i < 6; i++) begin
      rx_data_o = i / 2 == 1 ? ~dm : '1;
      #7.5;
      // pulses move mid-period so the falling-edge samplers never race them
      rx_fp_n_o = i / 2 == 1 ? ~rp : 4'hf;
      tx_fp_n_o = i / 2 == 1 ? ~tp : 4'hf;
      tx_fast_fp_n_o = !(i / 2 == 1 && f[2]);
      {rx_line_clock_o, tx_line_clock_o, rx_hwy_clock_o, tx_hwy_clock_o} = {rl, tl, rh, th};
      {rx_fast_o, tx_fast_o, tx_fp_clock_o} = {f[0], f[1], f[2]};
      #7.5;
      {rx_line_clock_o, tx_line_clock_o, rx_hwy_clock_o, tx_hwy_clock_o} = '0;
      {rx_fast_o, tx_fast_o, tx_fp_clock_o} = '0;
    end
  endtask
endmodule // link_activity_model
`default_nettype wire

// ---- link_clock_activity_monitor_tb_top.sv ----
// self-checking bench for the link and frame pulse activity monitor
`timescale 1ns/1ps
`default_nettype none
`include "link_activity_cfg.svh"
module link_clock_activity_monitor_tb_top;
  import link_activity_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic [`ACT_ADDR_W-1:0] addr = '0;
  logic [3:0] be_n = 4'hf;
  word_type rdata;
  logic rvalid;
  logic [31:0] rxd, rxl, txl;
  logic [3:0] rxh, txh, rxp, txp;
  logic rxf, txf, tfc, tfp;
  int error_cnt = 0;
  int checks = 0;
  always #50 ref_clk = ~ref_clk;
  link_activity_model i_model (.rx_data_o(rxd), .rx_line_clock_o(rxl), .rx_hwy_clock_o(rxh),
    .rx_fast_o(rxf), .rx_fp_n_o(rxp), .tx_line_clock_o(txl), .tx_hwy_clock_o(txh),
    .tx_fast_o(txf), .tx_fp_n_o(txp), .tx_fp_clock_o(tfc), .tx_fast_fp_n_o(tfp));
  link_clock_activity_monitor i_dut (.ref_clk_i(ref_clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_rd_i(rd), .byte_lane_enables_n_i(be_n), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .rx_data_i(rxd), .rx_line_clock_i(rxl), .rx_hwy_clock_i(rxh), .rx_fast_hwy_data_clock_i(rxf),
    .rx_hwy_frame_pulse_n_i(rxp), .tx_line_clock_i(txl), .tx_hwy_clock_i(txh),
    .tx_fast_hwy_data_clock_i(txf), .tx_hwy_frame_pulse_n_i(txp),
    .tx_fast_hwy_fp_clock_i(tfc), .tx_fast_hwy_frame_pulse_n_i(tfp));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic compare(input string name, input word_type exp, input word_type got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // strobe stays up between calls so reads run back to back; caller drops it
  task automatic read_chk(input string name, input logic [7:0] a, input logic [3:0] b,
                          input word_type exp);
    rd = 1'b1;
    addr = a;
    be_n = b;
    @(negedge ref_clk);
    compare({name, " valid"}, 32'h1, {31'h0, rvalid});
    compare(name, exp, rdata);
  endtask
  // --------------------------------------------------------------
  // one test: clear both registers, burst, then read and re-read
  // --------------------------------------------------------------
  task automatic scen(input string name, input logic [31:0] rl, tl, dm, input logic [3:0] rh,
                      th, rp, tp, input logic [2:0] f, input word_type el, ef);
    @(negedge ref_clk);
    rd = 1'b1;
    addr = 8'h10;
    be_n = 4'h0;
    @(negedge ref_clk);
    addr = 8'h0c;
    @(negedge ref_clk);
    rd = 1'b0;
    i_model.burst(rl, tl, dm, rh, th, rp, tp, f);
    repeat (6) @(negedge ref_clk);
    read_chk({name, " no lanes"}, 8'h10, 4'hf, '0);
    read_chk({name, " unmapped"}, 8'h14, 4'h0, '0);
    read_chk({name, " link"}, 8'h10, 4'h7, el);
    read_chk({name, " link clear"}, 8'h10, 4'h0, '0);
    read_chk({name, " pulses"}, 8'h0c, 4'he, ef);
    read_chk({name, " pulse clear"}, 8'h0c, 4'h0, '0);
    rd = 1'b0;
    $display("test %s done", name);
  endtask
  initial begin
    @(negedge ref_clk);
    i_model.burst('1, '1, '0, 4'hf, 4'hf, '0, '0, 3'h7);
    repeat (19) @(negedge ref_clk);
    rst = 1'b0;
    scen("rx line", 32'hf, '0, 32'hf, '0, '0, '0, '0, '0, 32'h01, '0);
    scen("rx three", 32'h7, '0, 32'hf, '0, '0, '0, '0, '0, '0, '0);
    scen("rx hwy", '0, '0, 32'hff00, 4'h2, '0, '0, '0, '0, 32'h0c, '0);
    scen("rx fast", '0, '0, 32'h11111111, '0, '0, '0, '0, 3'h1, 32'hff, '0);
    scen("rx mixed", 32'hf0, '0, 32'h0f0000f0, 4'h8, '0, '0, '0, '0, 32'h42, '0);
    scen("tx line", '0, 32'hf7ffff0f, '0, '0, '0, '0, '0, '0, 32'hbd00, '0);
    scen("tx hwy", '0, '0, '0, '0, 4'h5, '0, '0, 3'h2, 32'h8500, '0);
    scen("pulses", '0, '0, '0, 4'hf, 4'hf, 4'h5, 4'ha, 3'h4, 32'h0f00, 32'ha58);
    complete_run();
  end
  initial begin
    #200000;
    error_cnt++;
    $display("BAD run expected done seen hang");
    complete_run();
  end
endmodule // link_clock_activity_monitor_tb_top
`default_nettype wire
